// ==== core/rx_protect_pkg.sv ====
// constants and types shared by the cyclic receive protection block
// assumes nothing beyond a SystemVerilog compiler
package rx_protect_pkg;

  // error codes reported with the cyclic data alarms
  localparam logic [15:0] CODE_NONE   = 16'h0000;
  localparam logic [15:0] CODE_NODE   = 16'h0011;
  localparam logic [15:0] CODE_SUBCHK = 16'h0012;
  localparam logic [15:0] CODE_CMD    = 16'h0021;

  // field widths of the checked frame fields
  localparam int NODE_W = 5;  // byte 0 bits 4..0
  localparam int CMD_W  = 3;  // byte 1 bits 6..4

  // lowest threshold that enables the update counter alarm
  localparam logic [7:0] UPD_THR_MIN_ON = 8'h02;

  // link state of the communication state machine
  typedef enum logic [0:0] {
    LINK_INITIAL = 1'b0,
    LINK_RUNNING = 1'b1
  } link_state_type;

endpackage : rx_protect_pkg

// ==== core/upd_check_if.sv ====
// signals between the protection core and the update counter checker
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface upd_check_if #(parameter int UC_W = 8, parameter int THR_W = 8);
  logic             check;      // one-cycle read of a received frame
  logic             running;    // link is in RUNNING
  logic [UC_W-1:0]  count;      // host update counter of the frame
  logic [THR_W-1:0] threshold;  // programmed error threshold
  logic             alarm;      // sticky update counter alarm
  logic [THR_W:0]   errors;     // accumulated counter errors

  modport core    (output check, running, count, threshold, input alarm, errors);
  modport counter (input check, running, count, threshold, output alarm, errors);
endinterface : upd_check_if
`default_nettype wire

// ==== core/update_counter_check.sv ====
// update counter checker: accumulates counter slips, raises a sticky alarm
// assumes check pulses once per received frame on the core clock
`timescale 1ns/100ps
`default_nettype none
module update_counter_check
  import rx_protect_pkg::*;
#(
  parameter int UC_W  = 8,
  parameter int THR_W = 8
) (
  input wire logic       core_clk,
  input wire logic       rst,
  upd_check_if.counter   uc
);

  logic            have_prev;
  logic [UC_W-1:0] prev;
  logic [THR_W:0]  next_errors;
  wire             enabled;
  wire             slip;
  wire             saturated;

  // alarm is off entirely for thresholds 0 and 1
  assign enabled   = uc.threshold >= THR_W'(UPD_THR_MIN_ON);
  assign slip      = uc.check && have_prev && (uc.count != UC_W'(prev + 1'b1));
  assign saturated = &uc.errors;
  assign next_errors = (slip && !saturated) ? uc.errors + 1'b1 : uc.errors;

  // remember the last counter while the link runs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      have_prev <= 1'b0;
      prev      <= '0;
    end else if (!uc.running) begin
      have_prev <= 1'b0;
    end else if (uc.check) begin  // every read while running
      have_prev <= 1'b1;
      prev      <= uc.count;
    end
  end

  // error accumulation and a sticky alarm that only reset clears
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      uc.errors <= '0;
      uc.alarm  <= 1'b0;
    end else begin
      uc.errors <= next_errors;
      uc.alarm  <= uc.alarm | (enabled && next_errors > {1'b0, uc.threshold});
    end
  end

  AST_UPD_OFF: assert property (@(posedge core_clk) disable iff (rst)
    (uc.threshold < THR_W'(UPD_THR_MIN_ON)) && !uc.alarm |=> !uc.alarm)
    else $error("update counter alarm raised while disabled");

endmodule : update_counter_check
`default_nettype wire

// ==== core/cyclic_rx_error_protection.sv ====
// receive-side protection of cyclic command frames of a field-network slave
// assumes frame fields arrive decoded with a one-cycle rx_valid strobe on
// core_clk; the node switch is a slow pin and is synchronised here
`timescale 1ns/100ps
`default_nettype none
module cyclic_rx_error_protection
  import rx_protect_pkg::*;
#(
  parameter int          DATA_W          = 64,
  parameter int          UC_W            = 8,
  parameter int          THR_W           = 8,
  parameter int          SUBCHK_PERSIST  = 3,       // frames of sub-check loss
  parameter logic [7:0]  CMD_DEFINED     = 8'hFF,   // bit n set: code n defined
  parameter logic [15:0] CODE_DIR        = CODE_NONE
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic [NODE_W-1:0] node_switch,        // rotary switch pins
  input  wire logic              mode_32byte,
  input  wire logic              full_sync_mode,
  input  wire logic              sync_transient,
  input  wire logic [THR_W-1:0]  update_error_threshold,
  input  wire logic              link_start,
  input  wire logic              comm_error,
  input  wire logic              comm_timeout,
  input  wire logic              rx_valid,
  input  wire logic [NODE_W-1:0] node_address_field,
  input  wire logic              rx_dir,
  input  wire logic [CMD_W-1:0]  rx_cmd,
  input  wire logic              rx_subchk,
  input  wire logic [UC_W-1:0]   rx_update_count,
  input  wire logic              rx_alarm_clear,
  input  wire logic [DATA_W-1:0] rx_payload,
  output link_state_type         link_state,
  output logic                   cyclic_alarm1,
  output logic                   cyclic_alarm2,
  output logic                   update_counter_alarm,
  output logic                   interaxis_sync_alarm,
  output logic [15:0]            error_code,
  output logic [THR_W:0]         update_errors,
  output logic [DATA_W-1:0]      applied_data,
  output logic                   frame_applied
);

  localparam int SC_W = $clog2(SUBCHK_PERSIST + 1);

  logic [NODE_W-1:0] node_meta;
  logic [NODE_W-1:0] node_sync;
  logic [SC_W-1:0]   subchk_run;
  link_state_type    next_link_state;
  logic [15:0]       next_error_code;

  wire running;
  wire check;
  wire node_bad;
  wire dir_bad;
  wire cmd_bad;
  wire subchk_low;
  wire subchk_fault;
  wire a1_evt;
  wire a2_evt;
  wire frame_bad;
  wire clear_req;
  wire isync_evt;

  upd_check_if #(.UC_W(UC_W), .THR_W(THR_W)) uc ();

  // true when the command code is one of the defined cyclic commands
  function automatic logic cmd_defined(input logic [CMD_W-1:0] code);
    cmd_defined = CMD_DEFINED[code];
  endfunction : cmd_defined

  // switch pins cross into the clock domain through two flip-flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      node_meta <= '0;
      node_sync <= '0;
    end else begin
      node_meta <= node_switch;
      node_sync <= node_meta;
    end
  end

  // field checks of the received frame
  assign running      = (link_state == LINK_RUNNING);
  assign check        = rx_valid && running;
  assign node_bad     = node_address_field != node_sync;
  assign dir_bad      = rx_dir;
  assign cmd_bad      = !cmd_defined(rx_cmd);
  assign subchk_low   = mode_32byte && !rx_subchk;
  assign subchk_fault = subchk_low && (subchk_run >= SC_W'(SUBCHK_PERSIST - 1));
  assign a1_evt       = check && (node_bad || dir_bad || subchk_fault);
  assign a2_evt       = check && cmd_bad;
  assign frame_bad    = a1_evt || a2_evt;
  // an alarm clear only counts when carried by a clean frame
  assign clear_req    = rx_valid && rx_alarm_clear && !node_bad && !dir_bad
                        && !cmd_bad && !subchk_fault;
  assign isync_evt    = running && full_sync_mode && sync_transient
                        && (comm_error || comm_timeout);

  // consecutive frames with the sub-check bit low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      subchk_run <= '0;
    end else if (check) begin
      subchk_run <= (subchk_low && !subchk_fault) ? subchk_run + 1'b1 : '0;
    end
  end

  // error code of the newest alarm, node before sub-check before command
  always_comb begin
    next_error_code = error_code;
    if (clear_req) begin
      next_error_code = CODE_NONE;
    end
    if (a1_evt && node_bad) begin
      next_error_code = CODE_NODE;
    end else if (a1_evt && dir_bad) begin
      next_error_code = CODE_DIR;
    end else if (a1_evt) begin
      next_error_code = CODE_SUBCHK;
    end else if (a2_evt) begin
      next_error_code = CODE_CMD;
    end
  end

  // cyclic alarms are sticky, a new event wins over a clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cyclic_alarm1 <= 1'b0;
      cyclic_alarm2 <= 1'b0;
      error_code    <= CODE_NONE;
    end else begin
      cyclic_alarm1 <= a1_evt | (cyclic_alarm1 & ~clear_req);
      cyclic_alarm2 <= a2_evt | (cyclic_alarm2 & ~clear_req);
      error_code    <= next_error_code;
    end
  end

  // only clean frames reach the applied data; faulty ones are dropped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      applied_data  <= '0;
      frame_applied <= 1'b0;
    end else begin
      frame_applied <= check && !frame_bad;
      if (check && !frame_bad) begin
        applied_data <= rx_payload;
      end
    end
  end

  // link state: cyclic alarms leave it alone, the sync alarm drops it
  always_comb begin
    next_link_state = link_state;
    unique case (link_state)
      LINK_INITIAL: begin
        if (link_start) begin
          next_link_state = LINK_RUNNING;
        end
      end
      LINK_RUNNING: begin
        if (isync_evt) begin
          next_link_state = LINK_INITIAL;
        end
      end
    endcase
  end

  // link state register and the clearable sync alarm
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link_state           <= LINK_INITIAL;
      interaxis_sync_alarm <= 1'b0;
    end else begin
      link_state           <= next_link_state;
      interaxis_sync_alarm <= isync_evt | (interaxis_sync_alarm & ~clear_req);
    end
  end

  // update counter checker
  assign uc.check       = check;
  assign uc.running     = running;
  assign uc.count       = rx_update_count;
  assign uc.threshold   = update_error_threshold;
  assign update_counter_alarm = uc.alarm;
  assign update_errors  = uc.errors;

  update_counter_check #(
    .UC_W  (UC_W),
    .THR_W (THR_W)
  ) u_update_counter_check (
    .core_clk (core_clk),
    .rst      (rst),
    .uc       (uc.counter)
  );

  // a clean frame followed one cycle later by its apply strobe
  sequence s_clean_frame;
    check && !frame_bad;
  endsequence

  sequence s_applied;
    frame_applied && (applied_data == $past(rx_payload));
  endsequence

  AST_CMD_CODE: assert property (@(posedge core_clk) disable iff (rst)
    a2_evt && !a1_evt |=> cyclic_alarm2 && (error_code == CODE_CMD))
    else $error("undefined command not reported");

  AST_NODE_CODE: assert property (@(posedge core_clk) disable iff (rst)
    check && node_bad |=> cyclic_alarm1 && (error_code == CODE_NODE))
    else $error("node address fault not reported");

  AST_SUBCHK_CODE: assert property (@(posedge core_clk) disable iff (rst)
    check && subchk_fault && !node_bad && !dir_bad |=> error_code == CODE_SUBCHK)
    else $error("sub-check fault not reported");

  AST_DIR_FAULT: assert property (@(posedge core_clk) disable iff (rst)
    check && rx_dir |=> cyclic_alarm1 && !frame_applied)
    else $error("direction fault not raised");

  AST_SUBCHK_16: assert property (@(posedge core_clk) disable iff (rst)
    check && !mode_32byte && !node_bad && !dir_bad && !clear_req |=> !$rose(cyclic_alarm1))
    else $error("sub-check alarm outside 32-byte mode");

  AST_DISCARD: assert property (@(posedge core_clk) disable iff (rst)
    frame_bad |=> $stable(applied_data) && !frame_applied)
    else $error("faulty frame applied");

  AST_APPLY: assert property (@(posedge core_clk) disable iff (rst)
    s_clean_frame |=> s_applied)
    else $error("clean frame not applied");

  AST_RUN_KEEP: assert property (@(posedge core_clk) disable iff (rst)
    running && !isync_evt |=> running)
    else $error("link left RUNNING without sync alarm");

  AST_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
    clear_req && !a1_evt && !a2_evt |=> !cyclic_alarm1 && !cyclic_alarm2)
    else $error("alarm clear not honoured");

  AST_UPD_STICKY: assert property (@(posedge core_clk) disable iff (rst)
    update_counter_alarm |=> update_counter_alarm)
    else $error("update counter alarm cleared");

  AST_ISYNC: assert property (@(posedge core_clk) disable iff (rst)
    isync_evt |=> (link_state == LINK_INITIAL) && interaxis_sync_alarm)
    else $error("sync alarm did not drop link");

endmodule : cyclic_rx_error_protection
`default_nettype wire

// ==== tb/host_frame_model.sv ====
// host controller model: issues one cyclic command frame per renewal cycle
// assumes the bench calls send from its main process on core_clk
`timescale 1ns/100ps
`default_nettype none
module host_frame_model
  import rx_protect_pkg::*;
(
  input  wire logic              core_clk,
  output logic                   rx_valid,
  output logic [NODE_W-1:0]      node_address_field,
  output logic                   rx_dir,
  output logic [CMD_W-1:0]       rx_cmd,
  output logic                   rx_subchk,
  output logic [7:0]             rx_update_count,
  output logic                   rx_alarm_clear,
  output logic [63:0]            rx_payload
);
  // idle lines at time zero
  initial begin
    rx_valid = 1'b0;
    {node_address_field, rx_dir, rx_cmd, rx_subchk} = '0;
    {rx_update_count, rx_alarm_clear, rx_payload} = '0;
  end

  // one frame per renewal cycle; fields scramble once released
  task automatic send(input logic [4:0] n, input logic d, input logic [2:0] c,
                      input logic s, input logic [7:0] u, input logic a,
                      input logic [63:0] p);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    {node_address_field, rx_dir, rx_cmd, rx_subchk} <= {n, d, c, s};
    rx_update_count <= u;
    rx_alarm_clear <= a;  // alarm clear rides a normal frame
    rx_payload <= p;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    {node_address_field, rx_dir, rx_cmd, rx_subchk} <= ~{n, d, c, s};
    {rx_update_count, rx_alarm_clear, rx_payload} <= ~{u, a, p};
  endtask : send
endmodule : host_frame_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the cyclic receive protection block
// assumes the host model drives frames; bench drives all other inputs
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import rx_protect_pkg::*;
;
  localparam int          SUB_N   = 3;
  localparam logic [7:0]  CMD_SET = 8'hf7;     // code 3 left undefined
  localparam logic [15:0] DIR_CD  = 16'h0013;  // direction fault code
  logic core_clk = 1'b0, rst = 1'b1, link_start = 1'b0, comm_error = 1'b0;
  logic comm_timeout = 1'b0, mode_32byte = 1'b0, full_sync_mode = 1'b0;
  logic sync_transient = 1'b0, rx_valid, rx_dir, rx_subchk, rx_alarm_clear;
  logic [4:0] node_switch = 5'h00, node_address_field, sw, n;
  logic [2:0] rx_cmd, c;
  logic [7:0] update_error_threshold = 8'h02, rx_update_count, uc;
  logic [63:0] rx_payload, p, last;
  link_state_type link_state;
  logic cyclic_alarm1, cyclic_alarm2, update_counter_alarm, interaxis_sync_alarm;
  logic frame_applied, d, s;
  logic [15:0] error_code;
  logic [8:0] update_errors;
  logic [63:0] applied_data;
  int err_count = 0, checked = 0, k, j;
  integer seed = 18783;

  always #20 core_clk = ~core_clk;

  host_frame_model host (.core_clk(core_clk), .rx_valid(rx_valid),
    .node_address_field(node_address_field), .rx_dir(rx_dir), .rx_cmd(rx_cmd),
    .rx_subchk(rx_subchk), .rx_update_count(rx_update_count),
    .rx_alarm_clear(rx_alarm_clear), .rx_payload(rx_payload));

  cyclic_rx_error_protection #(.SUBCHK_PERSIST(SUB_N), .CMD_DEFINED(CMD_SET),
    .CODE_DIR(DIR_CD)) dut (.core_clk(core_clk), .rst(rst),
    .node_switch(node_switch), .mode_32byte(mode_32byte), .full_sync_mode(full_sync_mode),
    .sync_transient(sync_transient), .update_error_threshold(update_error_threshold),
    .link_start(link_start), .comm_error(comm_error), .comm_timeout(comm_timeout),
    .rx_valid(rx_valid), .node_address_field(node_address_field), .rx_dir(rx_dir),
    .rx_cmd(rx_cmd), .rx_subchk(rx_subchk), .rx_update_count(rx_update_count),
    .rx_alarm_clear(rx_alarm_clear), .rx_payload(rx_payload), .link_state(link_state),
    .cyclic_alarm1(cyclic_alarm1), .cyclic_alarm2(cyclic_alarm2),
    .update_counter_alarm(update_counter_alarm),
    .interaxis_sync_alarm(interaxis_sync_alarm), .error_code(error_code),
    .update_errors(update_errors), .applied_data(applied_data),
    .frame_applied(frame_applied));

  // compare one result and count it
  task automatic cmp(input string what, input logic [64:0] exp, input logic [64:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // expected code of a frame with a single fault
  function automatic logic [15:0] fault_code(input logic [4:0] fn, input logic fd,
                                             input logic [2:0] fc, input logic fs);
    if (fn != sw) return CODE_NODE;
    if (fd) return DIR_CD;
    if (!CMD_SET[fc]) return CODE_CMD;
    if (!fs && mode_32byte) return CODE_SUBCHK;
    return CODE_NONE;
  endfunction : fault_code

  // one frame, then settle past its answer edge
  task automatic frame(input logic [4:0] fn, input logic fd, input logic [2:0] fc,
                       input logic fs, input logic a, input logic [63:0] fp);
    host.send(fn, fd, fc, fs, uc, a, fp);
    #1;  // answer edge has just passed, frame_applied stands now
  endtask : frame

  task automatic start_link();
    @(posedge core_clk);
    link_start <= 1'b1;
    @(posedge core_clk);
    link_start <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask : start_link

  task automatic reset_dut(input logic [7:0] thr);
    @(posedge core_clk);
    rst <= 1'b1;
    update_error_threshold <= thr;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    start_link();
  endtask : reset_dut

  task automatic summarize();
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge core_clk);
    err_count++;
    summarize();
  end

  initial begin
    sw = 5'($random(seed));
    node_switch = sw;
    uc = 8'($random(seed));
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    update_error_threshold <= 8'h01;
    #1;
    cmp("link_state", LINK_INITIAL, link_state);
    cmp("alarms", 0, {cyclic_alarm1, cyclic_alarm2, update_counter_alarm, interaxis_sync_alarm});
    repeat (3) @(posedge core_clk);
    start_link();
    // clean random frames with random gaps, sub-check ignored in 16-byte mode
    for (k = 0; k < 20; k++) begin
      uc++;
      p = {$random(seed), $random(seed)};
      c = 3'($random(seed));
      if (!CMD_SET[c]) c = 3'h0;
      frame(sw, 1'b0, c, k[0], 1'b0, p);
      cmp("frame_applied", 1, frame_applied);
      cmp("applied_data", p, applied_data);
      cmp("alarm1", 0, cyclic_alarm1);
      repeat ($unsigned($random(seed)) % 3) @(posedge core_clk);
    end
    last = p;
    mode_32byte <= 1'b1;
    // each single field fault, then clear through a clean frame
    for (k = 0; k < 4; k++) begin
      {n, d, c, s} = {sw, 1'b0, 3'h1, 1'b1};
      case (k)
        0: n = sw ^ (5'($random(seed)) | 5'h01);
        1: d = 1'b1;
        2: c = 3'h3;
        default: s = 1'b0;
      endcase
      p = {$random(seed), $random(seed)};
      if (k == 3) begin
        for (j = 1; j < SUB_N; j++) begin
          frame(n, d, c, s, 1'b0, ~p);
          cmp("alarm1 early", 0, cyclic_alarm1);
        end
        last = ~p;  // early sub-check frames are still applied
      end
      frame(n, d, c, s, 1'b0, p);
      cmp("error_code", fault_code(n, d, c, s), error_code);
      cmp("alarm1", k != 2, cyclic_alarm1);
      cmp("alarm2", k == 2, cyclic_alarm2);
      cmp("frame_applied", 0, frame_applied);
      cmp("applied_data", last, applied_data);
      cmp("link_state", LINK_RUNNING, link_state);
      frame(sw, 1'b0, 3'h1, 1'b1, 1'b1, p);
      cmp("alarms cleared", 0, {cyclic_alarm1, cyclic_alarm2, error_code});
      cmp("applied_data", p, applied_data);
      last = p;
    end
    mode_32byte <= 1'b0;
    sync_transient <= 1'b1;
    // counter slips against thresholds 0, 1 and 2
    for (k = 0; k < 3; k++) begin
      reset_dut(8'(k));
      frame(sw, 1'b0, 3'h0, 1'b1, 1'b0, 64'h0);
      for (j = 1; j < 5; j++) begin
        uc += 8'h02;
        frame(sw, 1'b0, 3'h0, 1'b1, 1'b0, 64'(j));
        if (k == 2) cmp("update_errors", j, update_errors);
        cmp("update_alarm", k == 2 && j > 2, update_counter_alarm);
        cmp("applied", {1'b1, 64'(j)}, {frame_applied, applied_data});
        cmp("link_state", LINK_RUNNING, link_state);
      end
    end
    uc++;
    frame(sw, 1'b0, 3'h0, 1'b1, 1'b1, 64'h0);
    cmp("update_alarm sticky", 1, update_counter_alarm);
    // sync fault: error, timeout, and error outside the transient
    full_sync_mode <= 1'b1;
    for (k = 0; k < 3; k++) begin
      sync_transient <= (k != 2);
      @(posedge core_clk);
      if (k == 1) comm_timeout <= 1'b1;
      else comm_error <= 1'b1;
      @(posedge core_clk);
      {comm_error, comm_timeout} <= 2'b00;
      @(posedge core_clk);
      #1;
      cmp("sync_alarm", k != 2, interaxis_sync_alarm);
      cmp("link_state", k == 2 ? LINK_RUNNING : LINK_INITIAL, link_state);
      uc++;
      frame(sw, 1'b0, 3'h0, 1'b1, 1'b0, 64'h5);
      cmp("frame_applied", k == 2, frame_applied);
      uc++;
      frame(sw, 1'b0, 3'h0, 1'b1, 1'b1, 64'h6);
      cmp("sync_alarm cleared", 0, interaxis_sync_alarm);
      start_link();
    end
    summarize();
  end
endmodule : tb_top
`default_nettype wire
